// >>> shared/cbx_pkg.sv
package cbx_pkg;
    // wishbone byte addresses and address region codes
    localparam logic [8:0] ADR_INSTR = 9'h000;
    localparam logic [8:0] ADR_STATUS = 9'h004;
    localparam logic [8:0] ADR_PC = 9'h008;
    localparam logic [1:0] RGN_CTRL = 2'h0;
    localparam logic [1:0] RGN_GPR = 2'h1;
    localparam logic [1:0] RGN_IO = 2'h2;
    // status_flags_register bit positions, busy and illegal status read bits, reset values
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;
    localparam int FLG_T = 6;
    localparam int FLG_I = 7;
    localparam int STAT_BUSY = 8;
    localparam int STAT_ILL = 9;
    localparam logic [7:0] STATUS_FLAGS_REGISTER_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
    // pointer pairs, low register index; base of the immediate load registers
    localparam logic [4:0] PTR_X = 5'h1A;
    localparam logic [4:0] PTR_Y = 5'h1C;
    localparam logic [4:0] PTR_Z = 5'h1E;
    localparam logic [4:0] IMM_BASE = 5'h10;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_FIN = 3'b100
    } cbx_state_t;
    typedef struct packed {
        logic rd;
        logic [15:0] addr;
    } cbx_mem_req_t;
endpackage

// >>> design/cbx_core.sv
// Overview of operation
// RULE1 - overflow branches jump PC+k+1 on match
// RULE2 - interrupt-state branches jump PC+k+1 on match
// RULE3 - untaken branch one cycle, taken two
// RULE4 - io bit set, two cycles, flags kept
// RULE5 - io bit clear, two cycles, flags kept
// RULE6 - left shift, zero in, sets ZCNV
// RULE7 - right shift, zero in, sets ZCNV
// RULE8 - rotates through carry, one cycle, ZCNV
// RULE9 - arithmetic right shift keeps bit seven
// RULE10 - register bit copied into transfer flag
// RULE11 - transfer flag copied into register bit
// RULE12 - flag set/clear ops touch one flag
// RULE13 - interrupt enable/disable ops, one cycle
// RULE14 - register and pair copy, flags kept
// RULE15 - immediate load, one cycle, flags kept
// RULE16 - indirect load via pointer, two cycles
// RULE17 - post-increment load reads then bumps pointer
// RULE18 - pre-decrement load decrements then reads
// RULE19 - displacement load, pointer unchanged, two cycles
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module cbx_core import cbx_pkg::*; #(
    parameter int NUM_IO = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [8:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // data memory
    output cbx_mem_req_t mem_req_o,
    input wire logic [7:0] mem_rdata_i,
    // io registers and state
    output logic [NUM_IO*8-1:0] io_o,
    output logic busy_o
);
    if (NUM_IO != 32) begin : g_chk
        $error("io bit ops address exactly 32 registers");
    end
    cbx_state_t state;
    logic [7:0] gpr [32];
    logic [7:0] io [NUM_IO];
    logic [7:0] status_flags_register;
    logic [15:0] pc;
    logic [15:0] ir;
    logic illegal;
    logic [4:0] ld_dst;
    logic bus_acc;
    logic bus_wr;
    logic [1:0] rgn;
    logic [4:0] bidx;
    logic idle;

    // decode results
    logic next_fin;
    logic [15:0] next_pc;
    logic [7:0] next_status_flags_register;
    logic wr_en;
    logic wr_pair;
    logic [4:0] wr_idx;
    logic [15:0] wr_word;
    logic io_we;
    logic [4:0] io_idx;
    logic [7:0] io_val;
    logic ld_go;
    logic [15:0] ld_addr;
    logic next_ill;

    function automatic logic [15:0] rpair(input logic [4:0] i);
        return {gpr[5'(i + 5'h01)], gpr[i]};
    endfunction
    function automatic logic [7:0] shift_flags(input logic [7:0] sr,
                                               input logic [7:0] res,
                                               input logic c);
        logic [7:0] f;
        f = sr;
        f[FLG_C] = c;
        f[FLG_Z] = (res == 8'h00);
        f[FLG_N] = res[7];
        f[FLG_V] = res[7] ^ c;
        return f;
    endfunction

    assign idle = (state == ST_IDLE);
    assign busy_o = !idle;
    assign bus_acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr = bus_acc && wb_we_i && wb_sel_i[0];
    assign rgn = wb_adr_i[8:7];
    assign bidx = wb_adr_i[6:2];
    always_comb begin
        logic [4:0] d;
        logic [4:0] r;
        logic [7:0] dv;
        logic [7:0] res;
        logic [15:0] ptr;
        logic [4:0] pidx;
        d = ir[8:4];
        r = {ir[9], ir[3:0]};
        dv = gpr[d];
        res = 8'h00;
        ptr = 16'h0000;
        pidx = PTR_X;
        next_fin = 1'b0;
        next_pc = 16'(pc + 16'h0001);
        next_status_flags_register = status_flags_register;
        wr_en = 1'b0;
        wr_pair = 1'b0;
        wr_idx = d;
        wr_word = 16'h0000;
        io_we = 1'b0;
        io_idx = ir[7:3];
        io_val = 8'h00;
        ld_go = 1'b0;
        ld_addr = 16'h0000;
        next_ill = 1'b0;
        casez (ir)
            16'b1111_0???_????_????: begin
                // bit 10 low tests set, high tests clear
                if (status_flags_register[ir[2:0]] == !ir[10]) begin
                    next_pc = 16'(pc + {{9{ir[9]}}, ir[9:3]} + 16'h0001); // RULE1 RULE2
                    next_fin = 1'b1; // RULE3
                end
            end
            16'b1001_10?0_????_????: begin
                io_we = 1'b1;
                io_val = io[io_idx];
                io_val[ir[2:0]] = ir[9]; // RULE4 RULE5
                next_fin = 1'b1; // RULE4 RULE5
            end
            16'b0000_11??_????_????, 16'b0001_11??_????_????: begin
                // only the same-register forms belong here
                if (d == r) begin
                    res = ir[12] ? {dv[6:0], status_flags_register[FLG_C]} // RULE8
                                 : {dv[6:0], 1'b0}; // RULE6
                    next_status_flags_register = shift_flags(status_flags_register, res, dv[7]);
                    wr_en = 1'b1;
                    wr_word = {8'h00, res};
                end else begin
                    next_ill = 1'b1;
                end
            end
            16'b1001_010?_????_0101, 16'b1001_010?_????_0110,
            16'b1001_010?_????_0111: begin
                case (ir[1:0])
                    2'b01: res = {dv[7], dv[7:1]}; // RULE9
                    2'b10: res = {1'b0, dv[7:1]}; // RULE7
                    default: res = {status_flags_register[FLG_C], dv[7:1]}; // RULE8
                endcase
                next_status_flags_register = shift_flags(status_flags_register, res, dv[0]);
                wr_en = 1'b1;
                wr_word = {8'h00, res};
            end
            16'b1001_0100_????_1000: begin
                next_status_flags_register[ir[6:4]] = !ir[7]; // RULE12 RULE13
            end
            16'b1111_101?_????_0???: begin
                next_status_flags_register[FLG_T] = dv[ir[2:0]]; // RULE10
            end
            16'b1111_100?_????_0???: begin
                res = dv;
                res[ir[2:0]] = status_flags_register[FLG_T]; // RULE11
                wr_en = 1'b1;
                wr_word = {8'h00, res};
            end
            16'b0010_11??_????_????: begin
                wr_en = 1'b1;
                wr_word = {8'h00, gpr[r]}; // RULE14
            end
            16'b0000_0001_????_????: begin
                wr_en = 1'b1;
                wr_pair = 1'b1;
                wr_idx = {ir[7:4], 1'b0};
                wr_word = rpair({ir[3:0], 1'b0}); // RULE14
            end
            16'b1110_????_????_????: begin
                wr_en = 1'b1;
                wr_idx = IMM_BASE | {1'b0, ir[7:4]};
                wr_word = {8'h00, ir[11:8], ir[3:0]}; // RULE15
            end
            16'b1001_000?_????_1100, 16'b1001_000?_????_1101,
            16'b1001_000?_????_1110, 16'b1001_000?_????_1001,
            16'b1001_000?_????_1010, 16'b1001_000?_????_0001,
            16'b1001_000?_????_0010: begin
                pidx = (ir[3:2] == 2'b11) ? PTR_X :
                       (ir[3] ? PTR_Y : PTR_Z);
                ptr = rpair(pidx);
                ld_go = 1'b1;
                next_fin = 1'b1; // RULE16
                wr_pair = 1'b1;
                wr_idx = pidx;
                if (ir[1:0] == 2'b01) begin
                    ld_addr = ptr;
                    wr_en = 1'b1;
                    wr_word = 16'(ptr + 16'h0001); // RULE17
                end else if (ir[1:0] == 2'b10) begin
                    ld_addr = 16'(ptr - 16'h0001); // RULE18
                    wr_en = 1'b1;
                    wr_word = ld_addr;
                end else begin
                    ld_addr = ptr; // RULE16
                end
            end
            16'b10?0_??0?_????_????: begin
                ptr = rpair(ir[3] ? PTR_Y : PTR_Z);
                ld_addr = 16'(ptr + {10'h000, ir[13], ir[11:10], ir[2:0]}); // RULE19
                ld_go = 1'b1;
                next_fin = 1'b1; // RULE19
            end
            default: next_ill = 1'b1;
        endcase
    end

    // sequencer: one exec cycle, a second only when needed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (bus_wr && rgn == RGN_CTRL && wb_adr_i == ADR_INSTR
                        && wb_sel_i[1]) begin
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: state <= next_fin ? ST_FIN : ST_IDLE; // RULE3
                ST_FIN: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ir <= 16'h0000;
        end else if (idle && bus_wr && wb_adr_i == ADR_INSTR && wb_sel_i[1]) begin
            ir <= wb_dat_i[15:0];
        end
    end

    // flags and pc
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_flags_register <= STATUS_FLAGS_REGISTER_RST;
            pc <= PC_RST;
            illegal <= 1'b0;
        end else if (state == ST_EXEC) begin
            status_flags_register <= next_status_flags_register;
            pc <= next_pc;
            illegal <= illegal | next_ill;
        end else if (idle && bus_wr && wb_adr_i == ADR_STATUS) begin
            status_flags_register <= wb_dat_i[7:0];
            // a status write also drops the sticky illegal mark
            illegal <= 1'b0;
        end else if (idle && bus_wr && wb_adr_i == ADR_PC && wb_sel_i[1]) begin
            pc <= wb_dat_i[15:0];
        end
    end

    // working registers; bus writes only while idle, so no collision
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gpr <= '{default: 8'h00};
        end else if (idle) begin
            if (bus_wr && rgn == RGN_GPR) begin
                gpr[bidx] <= wb_dat_i[7:0];
            end
        end else if (state == ST_EXEC && wr_en) begin
            if (wr_pair) begin
                gpr[5'(wr_idx + 5'h01)] <= wr_word[15:8]; // RULE14
            end
            gpr[wr_idx] <= wr_word[7:0];
        end else if (state == ST_FIN && mem_req_o.rd) begin
            gpr[ld_dst] <= mem_rdata_i; // RULE16
        end
    end

    // io registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io <= '{default: 8'h00};
        end else if (idle && bus_wr && rgn == RGN_IO) begin
            io[bidx] <= wb_dat_i[7:0];
        end else if (state == ST_EXEC && io_we) begin
            io[io_idx] <= io_val; // RULE4 RULE5
        end
    end

    // load request stands for the second cycle only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_req_o <= '0;
            ld_dst <= 5'h00;
        end else if (state == ST_EXEC && ld_go) begin
            mem_req_o.rd <= 1'b1;
            mem_req_o.addr <= ld_addr; // RULE17 RULE18
            ld_dst <= ir[8:4];
        end else begin
            mem_req_o.rd <= 1'b0;
        end
    end

    // bus answer, one wait state; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_acc;
            wb_dat_o <= 32'h0000_0000;
            if (bus_acc && !wb_we_i) begin
                case (rgn)
                    RGN_CTRL: begin
                        if (wb_adr_i == ADR_INSTR) begin
                            wb_dat_o <= {16'h0000, ir};
                        end else if (wb_adr_i == ADR_STATUS) begin
                            wb_dat_o <= {22'h00_0000, illegal, !idle, status_flags_register};
                        end else if (wb_adr_i == ADR_PC) begin
                            wb_dat_o <= {16'h0000, pc};
                        end
                    end
                    RGN_GPR: wb_dat_o <= {24'h00_0000, gpr[bidx]};
                    RGN_IO: wb_dat_o <= {24'h00_0000, io[bidx]};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_IO; i++) begin
            io_o[i*8 +: 8] = io[i];
        end
    end
endmodule // cbx_core

// >>> test/cbx_core_chk.sv
`timescale 1ns/1ps
module cbx_core_chk import cbx_pkg::*; #(
    parameter int NUM_IO = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus side
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [8:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // core outputs
    input wire cbx_mem_req_t mem_req_o,
    input wire logic [NUM_IO*8-1:0] io_o,
    input wire logic busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic wr;
    logic go;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    // only a full-width opcode write may start work
    assign go = wr && wb_adr_i == ADR_INSTR && wb_sel_i[1:0] == 2'b11
        && !busy_o;
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    a_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack not one cycle after request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_exec_start: assert property (go |=> busy_o)
        else $error("opcode write did not start execution");
    a_busy_max: assert property (busy_o ##1 busy_o |=> !busy_o)
        else $error("execution longer than two cycles");
    a_load_pulse: assert property (mem_req_o.rd |=> !mem_req_o.rd)
        else $error("memory read longer than one cycle");
    a_load_late: assert property (mem_req_o.rd
        |-> busy_o && $past(busy_o))
        else $error("memory read not in second cycle");
    a_io_onebit: assert property (!$stable(io_o) && !$past(wr)
        |-> $onehot(io_o ^ $past(io_o)))
        else $error("io change touched more than one bit");
    a_io_busy: assert property (!$stable(io_o) && !$past(wr)
        |-> $past(busy_o) && busy_o)
        else $error("io bit change outside a two cycle op");
endmodule // cbx_core_chk

bind cbx_core cbx_core_chk #(.NUM_IO(NUM_IO)) u_chk (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_o,
    .wb_ack_o, .mem_req_o, .io_o, .busy_o);

// >>> test/cbx_core_bench.sv
`timescale 1ns/1ps
module cbx_core_bench import cbx_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [8:0] adr = 9'h0;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    cbx_mem_req_t mreq;
    logic [7:0] mv;
    logic [7:0] mdat;
    logic [255:0] io;
    logic busy;
    logic [31:0] q;
    logic [47:0] t;
    logic [15:0] pc_e = 16'h0;
    int bad_count = 0;
    int checks_done = 0;
    int busy_n = 0;
    int b0;
    // opcode, reg index, value, flags, busy cycles, pc step
    logic [47:0] tab [52] = '{
        48'hE801_3081_0011, 48'h0F00_3002_0911, 48'hE801_3081_0911,
        48'h9505_30C0_0511, 48'h9507_30E0_0C11, 48'h1F00_30C0_0511,
        48'h9506_3060_0011, 48'h9468_3060_4011, 48'hF900_3061_4011,
        48'h94E8_3061_0011, 48'hFB00_3061_4011, 48'h9408_3061_4111,
        48'h9488_3061_4011, 48'h9428_3061_4411, 48'h94A8_3061_4011,
        48'h9418_3061_4211, 48'h9498_3061_4011, 48'h9448_3061_5011,
        48'h94C8_3061_4011, 48'h9458_3061_6011, 48'h94D8_3061_4011,
        48'h9478_3061_C011, 48'hF017_3061_C023, 48'h94F8_3061_4011,
        48'h9438_3061_4811, 48'h94B8_3061_4011, 48'h9438_3061_4811,
        48'h2F10_3161_4811, 48'hF013_3161_4823, 48'hF413_3161_4811,
        48'hF017_3161_4811, 48'hF417_3161_4823, 48'hF7FF_3161_4820,
        48'h9A2B_45AD_4821, 48'h982B_45A5_4821, 48'h901D_211E_4821,
        48'h902E_221E_4821, 48'h903C_231E_4821, 48'h2E4A_2423_4811,
        48'h805D_252B_4821, 48'h2E6C_2610_4811, 48'hAC77_2703_4821,
        48'h8080_28C3_4821, 48'h015E_2A10_4811, 48'h015E_2B02_4811,
        48'h90C9_2C2E_4821, 48'h90CA_2C2E_4821, 48'hF413_3C10_4811,
        48'h90D1_2DC3_4821, 48'hF413_3F01_4811, 48'h90D2_2DC3_4821,
        48'hF413_3F00_4811};
    // pointers and io register 5 preset before the run
    logic [15:0] ini [7] = '{16'h3A23, 16'h3B01, 16'h3C10, 16'h3D02,
        16'h3EFF, 16'h3F00, 16'h45A5};
    // idle read data inverted so a stale byte never matches
    assign mv = mreq.addr[7:0] ^ mreq.addr[15:8] ^ 8'h3C;
    assign mdat = mreq.rd ? mv : ~mv;
    cbx_core u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .mem_req_o(mreq), .mem_rdata_i(mdat), .io_o(io), .busy_o(busy));
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (busy === 1'b1) busy_n <= busy_n + 1;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic w, input logic [8:0] a,
            input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic test_done();
        $display("checks %0d bad %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #(2000 * 40);
        bad_count++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, 9'h00C, 32'h0);
        chk(q, 32'h0);
        foreach (ini[i]) wb(1'b1, {ini[i][14:8], 2'b00}, {24'h0, ini[i][7:0]});
        // opcode write without the upper byte lane must be dropped
        sel <= 4'h1;
        wb(1'b1, ADR_INSTR, 32'h0000_E8FF);
        sel <= 4'hF;
        wb(1'b0, ADR_PC, 32'h0);
        chk(q, 32'h0);
        foreach (tab[i]) begin
            t = tab[i];
            b0 = busy_n;
            wb(1'b1, ADR_INSTR, {16'h0, t[47:32]});
            wb(1'b0, ADR_STATUS, 32'h0);
            chk(q, {24'h0, t[15:8]});
            chk(32'(busy_n - b0), {28'h0, t[7:4]});
            pc_e = pc_e + 16'(t[3:0]);
            wb(1'b0, ADR_PC, 32'h0);
            chk(q, {16'h0, pc_e});
            wb(1'b0, {t[30:24], 2'b00}, 32'h0);
            chk(q, {24'h0, t[23:16]});
        end
        chk({24'h0, io[47:40]}, 32'h0000_00A5);
        // unknown opcode is a one-cycle no-op that marks status
        b0 = busy_n;
        wb(1'b1, ADR_INSTR, 32'h0000_0000);
        pc_e = pc_e + 16'h0001;
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(q, 32'h0000_0248);
        chk(32'(busy_n - b0), 32'h0000_0001);
        wb(1'b0, ADR_PC, 32'h0);
        chk(q, {16'h0, pc_e});
        // status and pc writes set up a taken carry branch
        wb(1'b1, ADR_STATUS, 32'h0000_0081);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(q, 32'h0000_0081);
        wb(1'b1, ADR_PC, 32'h0000_0100);
        b0 = busy_n;
        wb(1'b1, ADR_INSTR, 32'h0000_F010);
        wb(1'b0, ADR_PC, 32'h0);
        chk(q, 32'h0000_0103);
        chk(32'(busy_n - b0), 32'h0000_0002);
        test_done();
    end
endmodule // cbx_core_bench
